// ===== gpp_defs.svh
// constants for the gpio port with external interrupt
// assumes inclusion by bare name from the sense, port and bench files
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
`define GPP_ADR_LATCH 4'h0
`define GPP_ADR_DIR 4'h4
`define GPP_ADR_OPT 4'h8
`define GPP_ADR_SENSE 4'hc
`define GPP_RST_BYTE 8'h00
`define GPP_RST_SENSE 2'h0
`define GPP_SENSE_LOW 2'h0
`define GPP_SENSE_RISE 2'h1
`define GPP_SENSE_FALL 2'h2
`define GPP_SENSE_BOTH 2'h3
`endif

// ===== gpp_pkg.sv
// types for the gpio port
// assumes gpp_defs.svh is on the include path
package gpp_pkg;
    typedef enum logic [1:0] {gpp_float_in, gpp_pull_in, gpp_od_out, gpp_pp_out} gpp_mode_e;
    typedef logic [7:0] gpp_byte_t;
endpackage

// ===== gpp_sense.sv
// per-pin event detector for all four sensitivity settings
// assumes synchronised pin level on the same clock
`include "gpp_defs.svh"
module gpp_sense
    import gpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lvl_i,
    input wire logic en_i,
    input wire logic [1:0] sense_i,
    output logic evt_o
);
    logic prev_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            prev_ff <= 1'b0;
        else
            prev_ff <= lvl_i;
    end

    // detection per pin, before any or into the vector
    always_comb
    begin
        unique case (sense_i)
            `GPP_SENSE_LOW: evt_o = en_i & ~lvl_i;
            `GPP_SENSE_RISE: evt_o = en_i & lvl_i & ~prev_ff;
            `GPP_SENSE_FALL: evt_o = en_i & ~lvl_i & prev_ff;
            `GPP_SENSE_BOTH: evt_o = en_i & (lvl_i ^ prev_ff);
        endcase
    end
endmodule

// ===== gpp_port.sv
// gpio port with external interrupt, wishbone register slave
// assumes a classic wishbone master on clk_i and a pad that resolves pin_oe_o
// What this block does
// - bit x of the latch, direction and option registers controls and reflects pin x only
// - input pin: latch read returns the synchronised pin level
// - writing the latch on an input pin leaves the pin undriven
// - option bit in input mode enables pull-up or interrupt variant
// - output pin driven from latch, latch read returns stored value
// - output option: push-pull or open-drain; open-drain one floats
// - interrupt input raises request on event matching programmed sensitivity
// - per-pin detection first, then or into the shared vector request
// - request latch is not software visible, clears on vector fetch
// - changing sensitivity bits clears the pending request
// - enabled alternate output overrides direction and option at the pad
// - alternate output forces output mode, drive style from peripheral
// - peripheral input pin stays readable through the latch register
// - input with alternate output: read returns alternate output state
// - output with alternate input: peripheral sees latch content
// - direction/option pairs: 00 float, 01 pull/irq, 10 od, 11 pp
// - request reaches cpu only in interrupt mode with mask inactive
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`include "gpp_defs.svh"
module gpp_port
    import gpp_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o,
    output logic [WIDTH-1:0] pull_en_o,
    input wire logic [WIDTH-1:0] alt_en_i,
    input wire logic [WIDTH-1:0] alt_is_out_i,
    input wire logic [WIDTH-1:0] alt_out_i,
    input wire logic [WIDTH-1:0] alt_od_i,
    output logic [WIDTH-1:0] alt_in_o,
    input wire logic cpu_irq_mask_i,
    input wire logic vec_fetch_i,
    output logic irq_req_o
);
    logic [WIDTH-1:0] pin_value_latch_ff;
    logic [WIDTH-1:0] pin_direction_ff;
    logic [WIDTH-1:0] pin_option_select_ff;
    logic [1:0] ext_irq_sense_reg_ff;
    logic [WIDTH-1:0] sync1_ff;
    logic [WIDTH-1:0] sync2_ff;
    logic [WIDTH-1:0] evt;
    logic [WIDTH-1:0] irq_en;
    logic pend_ff;
    logic req_fire;
    logic [31:0] nxt_dat;
    logic wr_stb;
    logic sense_wr;

    function automatic gpp_mode_e mode_of(input logic d, input logic o);
        mode_of = gpp_mode_e'({d, o});
    endfunction

    // write lands on the edge at which the master samples ack high
    assign wr_stb = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign sense_wr = wr_stb & (adr_i == `GPP_ADR_SENSE)
        & (dat_i[1:0] != ext_irq_sense_reg_ff);

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser, first stage read only by second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave, one wait state, ack drops after one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i & stb_i & ~ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_value_latch_ff <= `GPP_RST_BYTE;
            pin_direction_ff <= `GPP_RST_BYTE;
            pin_option_select_ff <= `GPP_RST_BYTE;
            ext_irq_sense_reg_ff <= `GPP_RST_SENSE;
        end
        else if (wr_stb)
        begin
            unique case (adr_i)
                `GPP_ADR_LATCH: pin_value_latch_ff <= dat_i[WIDTH-1:0];
                `GPP_ADR_DIR: pin_direction_ff <= dat_i[WIDTH-1:0];
                `GPP_ADR_OPT: pin_option_select_ff <= dat_i[WIDTH-1:0];
                `GPP_ADR_SENSE: ext_irq_sense_reg_ff <= dat_i[1:0];
                default: ;
            endcase
        end
    end

    // read mux; unmapped addresses read zero but still ack
    always_comb
    begin
        nxt_dat = '0;
        unique case (adr_i)
            `GPP_ADR_LATCH:
            begin
                for (int i = 0; i < WIDTH; i++)
                begin
                    if (alt_en_i[i] & alt_is_out_i[i] & ~pin_direction_ff[i])
                        nxt_dat[i] = alt_out_i[i];
                    else if (pin_direction_ff[i])
                        nxt_dat[i] = pin_value_latch_ff[i];
                    else
                        nxt_dat[i] = sync2_ff[i];
                end
            end
            `GPP_ADR_DIR: nxt_dat[WIDTH-1:0] = pin_direction_ff;
            `GPP_ADR_OPT: nxt_dat[WIDTH-1:0] = pin_option_select_ff;
            `GPP_ADR_SENSE: nxt_dat[1:0] = ext_irq_sense_reg_ff;
            default: nxt_dat = '0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (cyc_i & stb_i & ~ack_o & ~we_i)
            dat_o <= nxt_dat;
    end

    ////////////////////////////////////////////////////////////////////////
    // pad control per pin
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            gpp_mode_e md;
            logic alt_drv;
            assign md = mode_of(pin_direction_ff[g], pin_option_select_ff[g]);
            assign alt_drv = alt_en_i[g] & alt_is_out_i[g];
            assign irq_en[g] = (md == gpp_pull_in) & ~alt_en_i[g];

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pin_o[g] <= 1'b0;
                    pin_oe_o[g] <= 1'b0;
                    pull_en_o[g] <= 1'b0;
                    alt_in_o[g] <= 1'b0;
                end
                else
                begin
                    if (alt_drv)
                    begin
                        pin_o[g] <= alt_out_i[g];
                        pin_oe_o[g] <= ~(alt_od_i[g] & alt_out_i[g]);
                    end
                    else
                    begin
                        pin_o[g] <= pin_value_latch_ff[g];
                        pin_oe_o[g] <= (md == gpp_pp_out)
                            | ((md == gpp_od_out) & ~pin_value_latch_ff[g]);
                    end
                    // pull-up off while a peripheral drives the pin
                    pull_en_o[g] <= (md == gpp_pull_in) & ~alt_drv;
                    alt_in_o[g] <= pin_direction_ff[g] ? pin_value_latch_ff[g]
                        : sync2_ff[g];
                end
            end

            gpp_sense u_sense
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .lvl_i(sync2_ff[g]),
                .en_i(irq_en[g]),
                .sense_i(ext_irq_sense_reg_ff),
                .evt_o(evt[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // request latch; set wins over fetch clear, sense change clears it
    assign req_fire = |evt;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pend_ff <= 1'b0;
        else if (sense_wr)
            pend_ff <= 1'b0;
        else if (req_fire)
            pend_ff <= 1'b1;
        else if (vec_fetch_i)
            pend_ff <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_req_o <= 1'b0;
        else
            irq_req_o <= pend_ff & ~cpu_irq_mask_i;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

    property p_mask;
        @(posedge clk_i) disable iff (rst_i) cpu_irq_mask_i |=> !irq_req_o;
    endproperty
    a_mask: assert property (p_mask) else $error("request passed mask");

    property p_sense_clr;
        @(posedge clk_i) disable iff (rst_i) sense_wr |=> !pend_ff;
    endproperty
    a_sense_clr: assert property (p_sense_clr) else $error("sense change kept request");

    property p_fetch_clr;
        @(posedge clk_i) disable iff (rst_i)
            vec_fetch_i && !req_fire && !sense_wr |=> !pend_ff;
    endproperty
    a_fetch_clr: assert property (p_fetch_clr) else $error("fetch did not clear");

    property p_set;
        @(posedge clk_i) disable iff (rst_i) req_fire && !sense_wr |=> pend_ff;
    endproperty
    a_set: assert property (p_set) else $error("event lost");

    property p_in_float;
        @(posedge clk_i) disable iff (rst_i)
            !pin_direction_ff[0] && !alt_en_i[0] |=> !pin_oe_o[0];
    endproperty
    a_in_float: assert property (p_in_float) else $error("input pin driven");

    property p_pp;
        @(posedge clk_i) disable iff (rst_i)
            pin_direction_ff[0] && pin_option_select_ff[0] && !alt_en_i[0]
            |=> pin_oe_o[0] && pin_o[0] == $past(pin_value_latch_ff[0]);
    endproperty
    a_pp: assert property (p_pp) else $error("push-pull wrong");

    property p_od_float;
        @(posedge clk_i) disable iff (rst_i)
            pin_direction_ff[0] && !pin_option_select_ff[0] && pin_value_latch_ff[0]
            && !alt_en_i[0] |=> !pin_oe_o[0];
    endproperty
    a_od_float: assert property (p_od_float) else $error("open-drain drove one");

    property p_alt_pp;
        @(posedge clk_i) disable iff (rst_i)
            alt_en_i[0] && alt_is_out_i[0] && !alt_od_i[0] |=> pin_oe_o[0];
    endproperty
    a_alt_pp: assert property (p_alt_pp) else $error("alt output not forced");

    property p_alt_od;
        @(posedge clk_i) disable iff (rst_i)
            alt_en_i[0] && alt_is_out_i[0] && alt_od_i[0] && alt_out_i[0] |=> !pin_oe_o[0];
    endproperty
    a_alt_od: assert property (p_alt_od) else $error("alt open-drain drove one");

    property p_pull_off;
        @(posedge clk_i) disable iff (rst_i)
            !pin_option_select_ff[0] |=> !pull_en_o[0];
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull-up on without option");

    property p_alt_in;
        @(posedge clk_i) disable iff (rst_i)
            pin_direction_ff[0] |=> alt_in_o[0] == $past(pin_value_latch_ff[0]);
    endproperty
    a_alt_in: assert property (p_alt_in) else $error("peripheral input not from latch");

    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_req_o);
    c_fetch: cover property (@(posedge clk_i) disable iff (rst_i) pend_ff ##1 vec_fetch_i);
    c_alt: cover property (@(posedge clk_i) disable iff (rst_i) alt_en_i[0] && pin_oe_o[0]);
    c_sense_clr: cover property (@(posedge clk_i) disable iff (rst_i) pend_ff && sense_wr);
endmodule

// ===== gpp_pad_model.sv
// board side of the port: pad resolution with external drivers
// assumes the port's pad outputs and one clock for the float pattern
module gpp_pad_model
    import gpp_pkg::*;
(
    input wire logic clk_i,
    input wire gpp_byte_t pin_o_i,
    input wire gpp_byte_t oe_i,
    input wire gpp_byte_t pull_i,
    input wire gpp_byte_t ext_val_i,
    input wire gpp_byte_t ext_drv_i,
    output gpp_byte_t pad_o
);
    gpp_byte_t last_ff = 8'h00;
    ////////////////////////////////////////////////////////////////////
    // floating pad wanders: shows inverse of last level, never holds
    always @(posedge clk_i)
    begin
        last_ff <= pad_o;
    end
    // port drive wins, then board drive, then pull-up
    assign pad_o = (oe_i & pin_o_i) | (~oe_i & ext_drv_i & ext_val_i)
        | (~oe_i & ~ext_drv_i & (pull_i | ~last_ff));
endmodule

// ===== tb_gpp_port.sv
// self-checking bench for the gpio port
// assumes gpp_port, gpp_pad_model and the register offsets header
`include "gpp_defs.svh"
module tb_gpp_port
    import gpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {gpp_byte_t dir, opt, lat, ev, ed, oe, drv, pull, rd;} gpp_row_s;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, vf = 0, mask = 0;
    logic [3:0] adr = 4'h0, sel = 4'hf;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack_o, irq;
    gpp_byte_t ae = 0, aio = 0, ao = 0, aod = 0, ev = 0, ed = 0;
    gpp_byte_t pin, pin_o, oe, pull, ain, q;
    int fails = 0, checked = 0;
    gpp_row_s rows[3] = '{
        '{8'hf0, 8'hcc, 8'haa, 8'h05, 8'h0f, 8'hd0, 8'h80, 8'h0c, 8'ha5},
        '{8'h0f, 8'h33, 8'h5a, 8'ha0, 8'hf0, 8'h07, 8'h02, 8'h30, 8'haa},
        '{8'h00, 8'h00, 8'hff, 8'h3c, 8'hff, 8'h00, 8'h00, 8'h00, 8'h3c}};
    ////////////////////////////////////////////////////////////////////
    gpp_port #(.WIDTH(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin), .pin_o(pin_o),
        .pin_oe_o(oe), .pull_en_o(pull), .alt_en_i(ae), .alt_is_out_i(aio),
        .alt_out_i(ao), .alt_od_i(aod), .alt_in_o(ain),
        .cpu_irq_mask_i(mask), .vec_fetch_i(vf), .irq_req_o(irq));
    gpp_pad_model pad_u (.clk_i(clk_i), .pin_o_i(pin_o), .oe_i(oe),
        .pull_i(pull), .ext_val_i(ev), .ext_drv_i(ed), .pad_o(pin));
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input gpp_byte_t seen, input gpp_byte_t exp);
        checked++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask
    // classic cycle: hold until ack sampled, then release for a cycle
    task automatic wb(input logic w, input logic [3:0] a, input gpp_byte_t d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 12 && irq !== 1'b1; n++)
            @(posedge clk_i);
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_i);
        fails++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        for (int a = 0; a < 16; a += 2)
        begin
            wb(0, a[3:0], 8'h00);
            chk("reset reg", q, 8'h00);
        end
        chk("reset oe", oe, 8'h00);
        sel <= 4'he;
        wb(1, `GPP_ADR_DIR, 8'hff);
        sel <= 4'hf;
        wb(1, 4'h2, 8'hff);
        wb(0, `GPP_ADR_DIR, 8'h00);
        chk("masked write", q, 8'h00);
        $display("test reset done");
        foreach (rows[i])
        begin
            ev <= rows[i].ev;
            ed <= rows[i].ed;
            wb(1, `GPP_ADR_LATCH, rows[i].lat);
            wb(1, `GPP_ADR_DIR, rows[i].dir);
            wb(1, `GPP_ADR_OPT, rows[i].opt);
            repeat (4) @(posedge clk_i);
            chk("oe", oe, rows[i].oe);
            chk("drive", pin_o & oe, rows[i].drv);
            chk("pull", pull, rows[i].pull);
            wb(0, `GPP_ADR_LATCH, 8'h00);
            chk("latch", q, rows[i].rd);
            wb(0, `GPP_ADR_OPT, 8'h00);
            chk("option", q, rows[i].opt);
            $display("row %0d done", i);
        end
        wb(1, `GPP_ADR_OPT, 8'h03);
        wb(1, `GPP_ADR_SENSE, 8'h03);
        ed <= 8'h03;
        for (int s = 0; s < 4; s++)
        begin
            ev <= {6'h0, {2{s != 1}}};
            repeat (6) @(posedge clk_i);
            wb(1, `GPP_ADR_SENSE, gpp_byte_t'(s));
            repeat (2) @(posedge clk_i);
            chk("irq idle", {7'h0, irq}, 8'h00);
            ev[s % 2] <= (s == 1);
            wait_irq();
            chk("irq event", {7'h0, irq}, 8'h01);
            if (s != 0)
            begin
                vf <= 1;
                @(posedge clk_i);
                vf <= 0;
                repeat (2) @(posedge clk_i);
                chk("irq fetch", {7'h0, irq}, 8'h00);
            end
        end
        wb(1, `GPP_ADR_SENSE, 8'h01);
        ev <= 8'h00;
        repeat (6) @(posedge clk_i);
        ev <= 8'h01;
        wait_irq();
        chk("irq armed", {7'h0, irq}, 8'h01);
        wb(1, `GPP_ADR_SENSE, 8'h02);
        repeat (2) @(posedge clk_i);
        chk("irq sense", {7'h0, irq}, 8'h00);
        mask <= 1;
        ev <= 8'h00;
        repeat (8) @(posedge clk_i);
        chk("irq masked", {7'h0, irq}, 8'h00);
        $display("test irq done");
        mask <= 0;
        repeat (2) @(posedge clk_i);
        chk("irq unmasked", {7'h0, irq}, 8'h01);
        wb(1, `GPP_ADR_OPT, 8'h00);
        wb(1, `GPP_ADR_LATCH, 8'h02);
        wb(1, `GPP_ADR_DIR, 8'h02);
        ae <= 8'h07;
        aio <= 8'h01;
        ao <= 8'h01;
        ed <= 8'h04;
        ev <= 8'h04;
        repeat (5) @(posedge clk_i);
        chk("alt oe", oe & 8'h01, 8'h01);
        chk("alt out", pin_o & 8'h01, 8'h01);
        chk("alt in", ain & 8'h06, 8'h06);
        wb(0, `GPP_ADR_LATCH, 8'h00);
        chk("alt read", q & 8'h05, 8'h05);
        aod <= 8'h01;
        repeat (3) @(posedge clk_i);
        chk("alt od", oe & 8'h01, 8'h00);
        $display("test alternate done");
        ae <= 8'h00;
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        chk("late reset oe", oe, 8'h00);
        chk("late reset irq", {7'h0, irq}, 8'h00);
        wb(0, `GPP_ADR_DIR, 8'h00);
        chk("late reset dir", q, 8'h00);
        wb(0, `GPP_ADR_OPT, 8'h00);
        chk("late reset opt", q, 8'h00);
        wb(0, `GPP_ADR_SENSE, 8'h00);
        chk("late reset sense", q, 8'h00);
        $display("test late reset done");
        report_and_stop();
    end
endmodule
